// ===== design/rtcc_control_status.sv
// Purpose: control, flag and validity registers, update engine and user
//          ram of the clock, behind an index port and a data port
// Assumes: all inputs synchronous to clock; second_tick is one cycle
// Notes:   read data appears on io_rdata the cycle after io_rd
`timescale 1ns/100ps
module rtcc_control_status
   import rtcc_pkg::*;
#(
   parameter int UPD_CYCLES_P = UPDATE_CYCLES
)(
   // clock and resets
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       power_sense_reset_n,
   // host port
   input  wire logic [7:0] io_addr,
   input  wire logic       io_rd,
   input  wire logic       io_wr,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   // time base
   input  wire logic       second_tick,
   input  wire logic [15:0] divider_taps,
   input  wire logic [3:0] periodic_rate_select,
   // status
   output logic            irq_request,
   output logic            update_active
);
   localparam logic [UPD_CNT_W-1:0] UPD_LAST = UPD_CNT_W'(UPD_CYCLES_P - 1);

   // host-visible state
   logic [6:0] index_reg;
   logic       update_inhibit;
   logic       periodic_irq_enable;
   logic       alarm_irq_enable;
   logic       update_end_irq_enable;
   logic       hour_format_select;
   logic       daylight_saving_enable;
   logic       periodic_flag;
   logic       alarm_flag;
   logic       update_end_flag;
   logic       ram_time_valid;
   logic [7:0] time_reg [0:TIME_REG_COUNT-1];
   logic [7:0] ram [IDX_RAM_LO:IDX_RAM_HI];

   // update engine state
   rtcc_upd_e            upd_state;
   logic [UPD_CNT_W-1:0] upd_count;
   logic                 fall_done;
   logic                 tap_prev;

   // decode
   logic       index_wr;
   logic       data_wr;
   logic       data_rd;
   logic       sel_time;
   logic       sel_ctl;
   logic       sel_flg;
   logic       sel_vld;
   logic       sel_ram;
   logic       ctl_wr;
   logic       flg_rd;
   logic       vld_rd;
   logic       time_wr;
   logic       ram_wr;
   logic       inhibit_rise;
   logic       irq_summary_flag;
   logic [7:0] ctl_value;
   logic [7:0] flg_value;
   logic [7:0] vld_value;
   logic [7:0] read_mux;
   logic       tap_sel;
   logic       periodic_event;
   logic       upd_start;
   logic       upd_done;
   logic       alarm_hit;
   logic [2:0] slot_match;

   // next time from the stepper
   logic [7:0] next_sec;
   logic [7:0] next_min;
   logic [7:0] next_hour;
   logic [7:0] next_dow;
   logic [7:0] next_date;
   logic [7:0] next_month;
   logic [7:0] next_year;
   logic       fall_taken;

   // port decode: only the two documented addresses respond
   assign index_wr = io_wr && io_addr == INDEX_PORT;
   assign data_wr  = io_wr && io_addr == DATA_PORT;
   assign data_rd  = io_rd && io_addr == DATA_PORT;

   // index decode
   assign sel_time = index_reg < IDX_TIME_END;
   assign sel_ctl  = index_reg == IDX_CONTROL;
   assign sel_flg  = index_reg == IDX_FLAGS;
   assign sel_vld  = index_reg == IDX_VALID;
   assign sel_ram  = index_reg >= IDX_RAM_LO;

   // strobes; time bytes are shut off while an update runs
   assign ctl_wr  = data_wr && sel_ctl;
   assign flg_rd  = data_rd && sel_flg;
   assign vld_rd  = data_rd && sel_vld;
   assign time_wr = data_wr && sel_time && !update_active;
   assign ram_wr  = data_wr && sel_ram;
   assign inhibit_rise = ctl_wr && io_wdata[CTL_SET] && !update_inhibit;

   // register images; fixed and unused bits read zero
   assign irq_summary_flag = (periodic_flag && periodic_irq_enable) ||
                             (alarm_flag && alarm_irq_enable) ||
                             (update_end_flag &&
                              update_end_irq_enable);
   assign ctl_value = {update_inhibit, periodic_irq_enable,
                       alarm_irq_enable, update_end_irq_enable,
                       1'b0,
                       1'b0,
                       hour_format_select, daylight_saving_enable};
   assign flg_value = {irq_summary_flag, periodic_flag, alarm_flag,
                       update_end_flag, 4'h0};
   assign vld_value = {ram_time_valid, 7'h00};

   // read selection; index 0a belongs to the divider block, reads zero
   always_comb begin
      read_mux = 8'h00;
      if (sel_time) begin
         read_mux = update_active ? BLOCKED_READ
                                  : time_reg[index_reg[3:0]];
      end else if (sel_ctl) begin
         read_mux = ctl_value;
      end else if (sel_flg) begin
         read_mux = flg_value;
      end else if (sel_vld) begin
         read_mux = vld_value;
      end else if (sel_ram) begin
         read_mux = ram[index_reg];
      end
   end

   // periodic source: rising edge of the chosen divider tap
   assign tap_sel = (periodic_rate_select == 4'h0) ? 1'b0
                    : divider_taps[periodic_rate_select];
   assign periodic_event = tap_sel && !tap_prev;

   // update engine strobes
   assign upd_start     = second_tick && !update_inhibit &&
                          upd_state == UPD_IDLE;
   assign upd_done      = upd_state == UPD_RUN && !update_inhibit &&
                          upd_count == UPD_LAST;
   assign update_active = upd_state == UPD_RUN;
   assign irq_request   = irq_summary_flag;

   // alarm compare against the new time: sec, min, hour slots
   assign alarm_hit = &slot_match;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_alarm
         logic [7:0] cur;
         logic [7:0] alm;
         assign cur = (gi == 0) ? next_sec :
                      (gi == 1) ? next_min : next_hour;
         assign alm = time_reg[2 * gi + 1];
         assign slot_match[gi] =
            (alm & ALARM_DONT_CARE) == ALARM_DONT_CARE ||
            alm == cur;
      end
   endgenerate

   rtcc_time_step u_step (
      .sec        (time_reg[0]),
      .min        (time_reg[SLOT_MIN]),
      .hour       (time_reg[SLOT_HOUR]),
      .dow        (time_reg[SLOT_DOW]),
      .date       (time_reg[SLOT_DATE]),
      .month      (time_reg[SLOT_MONTH]),
      .year       (time_reg[SLOT_YEAR]),
      .hour_24    (hour_format_select),
      .dst_enable (daylight_saving_enable),
      .fall_done  (fall_done),
      .next_sec   (next_sec),
      .next_min   (next_min),
      .next_hour  (next_hour),
      .next_dow   (next_dow),
      .next_date  (next_date),
      .next_month (next_month),
      .next_year  (next_year),
      .fall_taken (fall_taken)
   );

   // index latch; bit 7 of the written byte is dropped
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         index_reg <= 7'h00;
      end else if (index_wr) begin
         index_reg <= io_wdata[6:0];
      end
   end

   // update cycle: inhibit aborts without touching the time
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         upd_state <= UPD_IDLE;
         upd_count <= '0;
      end else if (upd_state == UPD_IDLE) begin
         upd_count <= '0;
         if (upd_start) begin
            upd_state <= UPD_RUN;
         end
      end else if (update_inhibit || upd_done) begin
         upd_state <= UPD_IDLE;
         upd_count <= '0;
      end else begin
         upd_count <= upd_count + 1'b1;
      end
   end

   // time bytes: host writes when idle, stepper commits at update end
   always_ff @(posedge clock) begin
      if (!power_sense_reset_n) begin
         for (int i = 0; i < TIME_REG_COUNT; i++) begin
            time_reg[i] <= 8'h00;
         end
      end else if (upd_done) begin
         time_reg[0]          <= next_sec;
         time_reg[SLOT_MIN]   <= next_min;
         time_reg[SLOT_HOUR]  <= next_hour;
         time_reg[SLOT_DOW]   <= next_dow;
         time_reg[SLOT_DATE]  <= next_date;
         time_reg[SLOT_MONTH] <= next_month;
         time_reg[SLOT_YEAR]  <= next_year;
      end else if (time_wr) begin
         time_reg[index_reg[3:0]] <= io_wdata;
      end
   end

   // fall-back happens once; re-armed when the month leaves october
   always_ff @(posedge clock) begin
      if (!power_sense_reset_n) begin
         fall_done <= 1'b0;
      end else if (upd_done && fall_taken) begin
         fall_done <= 1'b1;
      end else if (time_reg[SLOT_MONTH] != BCD_OCTOBER) begin
         fall_done <= 1'b0;
      end
   end

   // user ram: no reset, kept alive by the battery supply
   always_ff @(posedge clock) begin
      if (ram_wr) begin
         ram[index_reg] <= io_wdata;
      end
   end

   // bits that survive system reset, defined at power-sense reset
   always_ff @(posedge clock) begin
      if (!power_sense_reset_n) begin
         update_inhibit         <= CTL_POWERUP;
         hour_format_select     <= CTL_POWERUP;
         daylight_saving_enable <= CTL_POWERUP;
      end else if (ctl_wr) begin
         update_inhibit         <= io_wdata[CTL_SET];
         hour_format_select     <= io_wdata[CTL_H24];
         daylight_saving_enable <= io_wdata[CTL_DSE];
      end
   end

   // interrupt enables cleared by system reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         periodic_irq_enable   <= 1'b0;
         alarm_irq_enable      <= 1'b0;
         update_end_irq_enable <= 1'b0;
      end else if (ctl_wr) begin
         periodic_irq_enable   <= io_wdata[CTL_PIE];
         alarm_irq_enable      <= io_wdata[CTL_AIE];
         update_end_irq_enable <= io_wdata[CTL_UIE] &&
                                  !inhibit_rise;
      end
   end

   // event flags: a set in the clearing read cycle wins, so no event
   // is lost; the read itself still returns the older image
   always_ff @(posedge clock) begin
      if (sys_rst || !power_sense_reset_n) begin
         periodic_flag   <= 1'b0;
         alarm_flag      <= 1'b0;
         update_end_flag <= 1'b0;
      end else begin
         periodic_flag   <= periodic_event ||
                            (periodic_flag && !flg_rd);
         alarm_flag      <= (upd_done && alarm_hit) ||
                            (alarm_flag && !flg_rd);
         update_end_flag <= upd_done ||
                            (update_end_flag && !flg_rd);
      end
   end

   // divider tap history for edge detection
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tap_prev <= 1'b1;                 // a tap already high is no edge
      end else begin
         tap_prev <= tap_sel;
      end
   end

   // validity bit: held low under power-sense reset, set by its read
   always_ff @(posedge clock) begin
      if (!power_sense_reset_n) begin
         ram_time_valid <= 1'b0;
      end else if (vld_rd) begin
         ram_time_valid <= 1'b1;
      end
   end

   // read data register; writes to flag or validity index do nothing
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         io_rdata <= 8'h00;
      end else if (data_rd) begin
         io_rdata <= read_mux;
      end
   end
endmodule : rtcc_control_status

// ===== design/rtcc_pkg.sv
// Purpose: shared constants and types of the clock control/status block
// Assumes: 100 MHz clock, host reaches the block through index/data ports
// Notes:   all time and calendar bytes are BCD
package rtcc_pkg;
   // host port addresses
   localparam logic [7:0] INDEX_PORT       = 8'h70;
   localparam logic [7:0] DATA_PORT        = 8'h71;
   // register indices
   localparam logic [6:0] IDX_SEC          = 7'h00;
   localparam logic [6:0] IDX_TIME_END     = 7'h0a;
   localparam logic [6:0] IDX_CONTROL      = 7'h0b;
   localparam logic [6:0] IDX_FLAGS        = 7'h0c;
   localparam logic [6:0] IDX_VALID        = 7'h0d;
   localparam logic [6:0] IDX_RAM_LO       = 7'h0e;
   localparam logic [6:0] IDX_RAM_HI       = 7'h7f;
   // time array slots: alarm byte sits right after its time byte
   localparam int         TIME_REG_COUNT   = 10;
   localparam int         SLOT_MIN         = 2;
   localparam int         SLOT_HOUR        = 4;
   localparam int         SLOT_DOW         = 6;
   localparam int         SLOT_DATE        = 7;
   localparam int         SLOT_MONTH       = 8;
   localparam int         SLOT_YEAR        = 9;
   // control register bit positions
   localparam int         CTL_SET          = 7;
   localparam int         CTL_PIE          = 6;
   localparam int         CTL_AIE          = 5;
   localparam int         CTL_UIE          = 4;
   localparam int         CTL_H24          = 1;
   localparam int         CTL_DSE          = 0;
   // values seen at power-sense reset and on blocked reads, and the alarm don't-care code
   localparam logic       CTL_POWERUP      = 1'b0;
   localparam logic [7:0] BLOCKED_READ     = 8'hff;
   localparam logic [7:0] ALARM_DONT_CARE  = 8'hc0;
   // bcd calendar codes
   localparam logic [7:0] BCD_59           = 8'h59;
   localparam logic [7:0] BCD_SUNDAY       = 8'h01;
   localparam logic [7:0] BCD_SATURDAY     = 8'h07;
   localparam logic [7:0] BCD_APRIL        = 8'h04;
   localparam logic [7:0] BCD_OCTOBER      = 8'h10;
   localparam logic [7:0] BCD_DECEMBER     = 8'h12;
   localparam logic [7:0] SPRING_LAST_DATE = 8'h07;
   localparam logic [7:0] FALL_FIRST_DATE  = 8'h25;
   localparam logic [7:0] HOUR_1AM         = 8'h01;
   localparam logic [7:0] HOUR_3AM         = 8'h03;
   // update cycle length
   localparam int         CLK_PERIOD_NS    = 10;
   localparam int         UPDATE_TIME_NS   = 2000000;
   localparam int         UPDATE_CYCLES    = UPDATE_TIME_NS / CLK_PERIOD_NS;
   localparam int         UPD_CNT_W        = 18;
   typedef enum logic {UPD_IDLE, UPD_RUN} rtcc_upd_e;
endpackage : rtcc_pkg

// ===== design/rtcc_time_step.sv
// Purpose: next-second time and calendar value, with daylight exceptions
// Assumes: inputs hold legal bcd codes
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
module rtcc_time_step
   import rtcc_pkg::*;
(
   // current time
   input  wire logic [7:0] sec,
   input  wire logic [7:0] min,
   input  wire logic [7:0] hour,
   input  wire logic [7:0] dow,
   input  wire logic [7:0] date,
   input  wire logic [7:0] month,
   input  wire logic [7:0] year,
   // mode
   input  wire logic       hour_24,
   input  wire logic       dst_enable,
   input  wire logic       fall_done,
   // next time
   output logic      [7:0] next_sec,
   output logic      [7:0] next_min,
   output logic      [7:0] next_hour,
   output logic      [7:0] next_dow,
   output logic      [7:0] next_date,
   output logic      [7:0] next_month,
   output logic      [7:0] next_year,
   output logic            fall_taken
);
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction : bcd_inc

   logic       leap;
   logic [7:0] days_max;
   logic       at_159;
   logic       spring;
   logic       fall;
   // leap year in bcd: even tens with 0/4/8, odd tens with 2/6
   assign leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                         : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                            year[3:0] == 4'h8);
   assign days_max = (month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                     (month == 8'h04 || month == 8'h06 ||
                      month == 8'h09 || month == 8'h11) ? 8'h30 : 8'h31;
   assign at_159 = hour == HOUR_1AM && min == BCD_59 && sec == BCD_59;
   assign spring = dst_enable && at_159 && month == BCD_APRIL &&
                   dow == BCD_SUNDAY && date <= SPRING_LAST_DATE;
   assign fall = dst_enable && at_159 && !fall_done &&
                 month == BCD_OCTOBER && dow == BCD_SUNDAY &&
                 date >= FALL_FIRST_DATE;

   // one-second step; 12 h mode keeps the pm flag in bit 7
   always_comb begin
      logic day_roll;
      day_roll   = 1'b0;
      next_sec   = bcd_inc(sec);
      next_min   = min;
      next_hour  = hour;
      next_dow   = dow;
      next_date  = date;
      next_month = month;
      next_year  = year;
      fall_taken = fall;
      if (fall) begin
         next_sec  = 8'h00;
         next_min  = 8'h00;
         next_hour = HOUR_1AM;
      end else if (sec == BCD_59) begin
         next_sec = 8'h00;
         next_min = bcd_inc(min);
         if (min == BCD_59) begin
            next_min = 8'h00;
            if (spring) begin
               next_hour = HOUR_3AM;
            end else if (hour_24) begin
               next_hour = bcd_inc(hour);
               if (hour == 8'h23) begin
                  next_hour = 8'h00;
                  day_roll  = 1'b1;
               end
            end else if (hour[6:0] == 7'h12) begin
               next_hour = {hour[7], 7'h01};
            end else if (hour[6:0] == 7'h11) begin
               next_hour = {~hour[7], 7'h12};
               day_roll  = hour[7];
            end else begin
               next_hour = bcd_inc(hour);
            end
         end
      end
      if (day_roll) begin
         next_dow  = (dow == BCD_SATURDAY) ? BCD_SUNDAY : bcd_inc(dow);
         next_date = bcd_inc(date);
         if (date == days_max) begin
            next_date  = 8'h01;
            next_month = bcd_inc(month);
            if (month == BCD_DECEMBER) begin
               next_month = 8'h01;
               next_year  = (year == 8'h99) ? 8'h00 : bcd_inc(year);
            end
         end
      end
   end
endmodule : rtcc_time_step

// ===== tb/rtcc_props.sv
// Purpose: port-level checks of the clock control/status block
// Assumes: index shadow tracks host writes to the index port
// Notes:   flag and enable state is judged through data-port reads
`timescale 1ns/100ps
module rtcc_props
   import rtcc_pkg::*;
#(
   parameter int UPD_CYCLES_P = 4
)(
   // everything is watched, nothing driven
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        power_sense_reset_n,
   input wire logic [7:0]  io_addr,
   input wire logic        io_rd,
   input wire logic        io_wr,
   input wire logic [7:0]  io_wdata,
   input wire logic [7:0]  io_rdata,
   input wire logic        second_tick,
   input wire logic [15:0] divider_taps,
   input wire logic [3:0]  periodic_rate_select,
   input wire logic        irq_request,
   input wire logic        update_active
);
   logic [6:0] idx;
   wire logic  rd_data;
   assign rd_data = io_rd && io_addr == DATA_PORT;
   // shadow of the index so each read knows which register answered
   always_ff @(posedge clock) begin
      if (sys_rst) idx <= 7'h00;
      else if (io_wr && io_addr == INDEX_PORT) idx <= io_wdata[6:0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_RST_QUIET: assert property ($fell(sys_rst) |->
      io_rdata == 8'h00 && !update_active && !irq_request)
      else $error("outputs not quiet after reset");
   AST_UPD_START: assert property ($rose(update_active) |->
      $past(second_tick)) else $error("update began without a tick");
   AST_UPD_LEN: assert property ($rose(update_active) |->
      ##[1:UPD_CYCLES_P] !update_active) else $error("update too long");
   AST_FLAG_CLEAR: assert property (rd_data && idx == IDX_FLAGS
      && !update_active && periodic_rate_select == 4'h0 |=> !irq_request)
      else $error("flag read left the request up");
   AST_SUMMARY: assert property (rd_data && idx == IDX_FLAGS |=>
      io_rdata[7] == $past(irq_request)) else $error("summary bit wrong");
   AST_UNUSED: assert property (rd_data && idx == IDX_FLAGS |=>
      io_rdata[3:0] == 4'h0) else $error("unused flag bits set");
   AST_VALID: assert property (rd_data && idx == IDX_VALID |=>
      io_rdata[6:0] == 7'h00 && (power_sense_reset_n || !io_rdata[7]))
      else $error("validity register image wrong");
   AST_CTL_FIXED: assert property (rd_data && idx == IDX_CONTROL |=>
      io_rdata[3:2] == 2'b00) else $error("fixed control bits set");
   AST_BLOCKED: assert property (rd_data && idx < TIME_REG_COUNT
      && update_active |=> io_rdata == BLOCKED_READ)
      else $error("time byte readable during update");
   AST_RDATA_HOLD: assert property (!rd_data && !sys_rst |=>
      $stable(io_rdata)) else $error("read data moved without a read");
endmodule : rtcc_props
bind rtcc_control_status rtcc_props #(.UPD_CYCLES_P(UPD_CYCLES_P)) i_props (
   .clock(clock), .sys_rst(sys_rst), .power_sense_reset_n(power_sense_reset_n),
   .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
   .io_rdata(io_rdata), .second_tick(second_tick), .divider_taps(divider_taps),
   .periodic_rate_select(periodic_rate_select), .irq_request(irq_request),
   .update_active(update_active));

// ===== tb/rtcc_host.sv
// Purpose: host processor model on the index/data ports
// Assumes: one strobe cycle per access, read data one cycle later
// Notes:   signals change only at rising edges
`timescale 1ns/100ps
module rtcc_host
   import rtcc_pkg::*;
(
   // host port
   input  wire logic       clock,
   output logic      [7:0] io_addr,
   output logic            io_rd,
   output logic            io_wr,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata
);
   initial begin
      io_addr = 8'h00;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
   end
   // strobe drops at the next edge, so re-entry never hits the same step
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clock);
      io_addr <= a;
      io_wdata <= x;
      io_wr <= 1'b1;
      @(posedge clock);
      io_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      @(posedge clock);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      #1 x = io_rdata;
   endtask : rd
endmodule : rtcc_host

// ===== tb/rtc_control_status_and_ram_bench.sv
// Purpose: self-checking bench of the clock control/status block
// Assumes: update shortened to 40 cycles so bus traffic fits inside one
// Notes:   expected images come from the bench's own control/ram model
`timescale 1ns/100ps
module rtc_control_status_and_ram_bench;
   import rtcc_pkg::*;
   logic        clock = 0, sys_rst = 1, power_sense_reset_n = 0;
   logic        second_tick = 0, io_rd, io_wr, irq_request, update_active;
   logic [15:0] divider_taps = 16'h0000;
   logic [3:0]  periodic_rate_select = 4'h0;
   logic [7:0]  io_addr, io_wdata, io_rdata, d, v, mctl = 8'h00;
   logic [7:0]  mram [128];
   int          failures = 0, comparisons = 0, seed = 32'h6faf;
   always #5 clock = ~clock;
   rtcc_host i_host (.clock(clock), .io_addr(io_addr), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata));
   rtcc_control_status #(.UPD_CYCLES_P(40)) i_dut (.clock(clock),
      .sys_rst(sys_rst), .power_sense_reset_n(power_sense_reset_n),
      .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .second_tick(second_tick),
      .divider_taps(divider_taps), .periodic_rate_select(periodic_rate_select),
      .irq_request(irq_request), .update_active(update_active));
   task automatic test_done;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [6:0] i, input logic [7:0] x);
      i_host.wr(INDEX_PORT, {1'b0, i});
      i_host.wr(DATA_PORT, x);
   endtask : reg_wr
   task automatic reg_chk(input logic [6:0] i, input logic [7:0] e);
      logic [7:0] r;
      i_host.wr(INDEX_PORT, {1'b0, i});
      i_host.rd(DATA_PORT, r);
      chk(r, e);
   endtask : reg_chk
   // model: raising inhibit drops the update-end enable, bits 3:2 fixed
   task automatic ctl_wr(input logic [7:0] x);
      mctl = x & ((x[7] && !mctl[7]) ? 8'he3 : 8'hf3);
      reg_wr(IDX_CONTROL, x);
   endtask : ctl_wr
   task automatic tick;
      @(posedge clock) second_tick <= 1'b1;
      @(posedge clock) second_tick <= 1'b0;
   endtask : tick
   // bounded wait for the engine to go idle
   task automatic wait_idle;
      int n;
      // let the edge that launched the update settle before looking
      @(negedge clock);
      for (n = 0; n < 100 && update_active !== 1'b0; n++) @(negedge clock);
      if (n == 100) begin
         failures++;
         test_done();
      end
   endtask : wait_idle
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      power_sense_reset_n <= 1'b1;
      reg_wr(IDX_VALID, 8'hff);
      reg_chk(IDX_VALID, 8'h00);
      reg_chk(IDX_VALID, 8'h80);
      for (int k = 0; k < 4; k++) begin
         v = 8'($random(seed));
         ctl_wr({1'b0, v[6:0]});
         reg_chk(IDX_CONTROL, mctl);
      end
      ctl_wr(8'h93);
      reg_chk(IDX_CONTROL, 8'h83);
      ctl_wr(8'hf3);
      @(posedge clock) sys_rst <= 1'b1;
      @(posedge clock) sys_rst <= 1'b0;
      reg_chk(IDX_CONTROL, 8'h83);
      reg_chk(IDX_VALID, 8'h80);
      reg_wr(IDX_FLAGS, 8'hff);
      reg_chk(IDX_FLAGS, 8'h00);
      ctl_wr(8'h12);
      tick();
      foreach (mram[i]) mram[i] = 8'($random(seed));
      reg_wr(IDX_RAM_LO, mram[IDX_RAM_LO]);
      reg_wr(IDX_RAM_HI, mram[IDX_RAM_HI]);
      reg_chk(IDX_RAM_LO, mram[IDX_RAM_LO]);
      reg_chk(IDX_SEC, BLOCKED_READ);
      reg_chk(IDX_RAM_HI, mram[IDX_RAM_HI]);
      wait_idle();
      chk({7'h00, irq_request}, 8'h01);
      reg_chk(IDX_FLAGS, 8'h90);
      reg_chk(IDX_FLAGS, 8'h00);
      chk({7'h00, irq_request}, 8'h00);
      reg_chk(IDX_SEC, 8'h01);
      tick();
      ctl_wr(8'h82);
      wait_idle();
      reg_chk(IDX_FLAGS, 8'h00);
      reg_chk(IDX_CONTROL, 8'h82);
      tick();
      @(negedge clock);
      chk({7'h00, update_active}, 8'h00);
      ctl_wr(8'h22);
      for (int k = 1; k < 6; k += 2) reg_wr(k[6:0], ALARM_DONT_CARE);
      tick();
      wait_idle();
      reg_chk(IDX_FLAGS, 8'hb0);
      @(posedge clock) periodic_rate_select <= 4'h3;
      for (int p = 0; p < 2; p++) begin
         ctl_wr(p ? 8'h42 : 8'h02);
         @(posedge clock) divider_taps <= 16'h0000;
         @(posedge clock) divider_taps <= 16'h0008;
         reg_chk(IDX_FLAGS, p ? 8'hc0 : 8'h40);
      end
      @(posedge clock) periodic_rate_select <= 4'h0;
      @(posedge clock) divider_taps <= 16'($random(seed));
      @(posedge clock) divider_taps <= ~divider_taps;
      reg_chk(IDX_FLAGS, 8'h00);
      // daylight exceptions at 01:59:59: spring to 3 am, fall to 1 am
      for (int s = 0; s < 2; s++) begin
         ctl_wr(8'h03);
         reg_wr(IDX_SEC, BCD_59);
         reg_wr(7'h02, BCD_59);
         reg_wr(7'h04, HOUR_1AM);
         reg_wr(7'h06, BCD_SUNDAY);
         reg_wr(7'h07, s ? FALL_FIRST_DATE : 8'h01);
         reg_wr(7'h08, s ? BCD_OCTOBER : BCD_APRIL);
         tick();
         wait_idle();
         reg_chk(7'h04, s ? HOUR_1AM : HOUR_3AM);
      end
      // power-sense pulse drops pending flags and validity on its own
      @(posedge clock) power_sense_reset_n <= 1'b0;
      @(posedge clock) power_sense_reset_n <= 1'b1;
      reg_chk(IDX_FLAGS, 8'h00);
      reg_chk(IDX_VALID, 8'h00);
      test_done();
   end
endmodule : rtc_control_status_and_ram_bench
